// file: p4fs_pkg.sv
// Package for the port 4 function-select block: register offsets,
// reset values, selector and drive-type codes, and the peripheral bundles.
// Assumes a byte-addressed register port with an optional 16-bit access.
package p4fs_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_PIN_DATA = 16'hF220;
   localparam logic [15:0] OFS_PIN_DIR = 16'hF221;
   localparam logic [15:0] OFS_DRIVE_LOW = 16'hF222;
   localparam logic [15:0] OFS_DRIVE_HIGH = 16'hF223;
   localparam logic [15:0] OFS_FUNC_LOW = 16'hF224;
   localparam logic [15:0] OFS_FUNC_HIGH = 16'hF225;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FUNC = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_DRIVE = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;

   // ----------------------------------------------------------------
   // Function selector codes {high bit, low bit}
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_GPIO = 2'h0;
   localparam logic [1:0] SEL_SECOND = 2'h1;
   localparam logic [1:0] SEL_THIRD = 2'h2;
   localparam logic [1:0] SEL_BANNED = 2'h3;

   // ----------------------------------------------------------------
   // Drive / pull type codes {high bit, low bit}
   // ----------------------------------------------------------------
   localparam logic [1:0] DRV_HIZ = 2'h0;
   localparam logic [1:0] DRV_PCH_OD = 2'h1;
   localparam logic [1:0] DRV_NCH_OD = 2'h2;
   localparam logic [1:0] DRV_CMOS = 2'h3;

   // First pin given over to the converter during conversion
   localparam int CONV_FIRST_PIN = 4;

   // ----------------------------------------------------------------
   // Peripheral bundles
   // ----------------------------------------------------------------
   typedef struct packed {
      logic asyncTransmitLine;
      logic pulseWidthOutZero;
      logic syncSerialDataOut;
      logic syncSerialClockOut;
      logic i2cClockOut;
      logic i2cDataOut;
      logic sensorResistorOut;
      logic refResistorOut;
      logic refCapacitorOut;
      logic convBusy;
   } p4fs_periph_out_s;

   typedef struct packed {
      logic asyncReceiveLine;
      logic syncSerialDataIn;
      logic syncSerialClockIn;
      logic i2cClockIn;
      logic i2cDataIn;
      logic oscWaveformInput;
   } p4fs_periph_in_s;

endpackage

// file: p4fs_port.sv
// Port 4 pin multiplexer: register file, per-pin function select and
// the electrical control of eight two-way pins.
// Assumes pins arrive from outside the clock domain and that on-chip
// peripherals run on clk_sys.
//
// Behaviour
// - Two mode registers give each pin selector
// - Mode registers reset zero; byte or word
// - Pin 7: 01 sensor resistor, 10 and 11 banned
// - Pin 6: resistor ref, serial data out
// - Pin 5: capacitor ref, serial clock
// - Pin 4: oscillation input, serial data in
// - Pin 3: async transmit, pulse width out
// - Pin 2: async receive, serial data out
// - Pin 1: I2C clock, serial clock
// - Pin 0: I2C data, serial data in
// - Banned code in output: fixed pin state
// - Direction bit chooses input or output
// - Output drive type from control pair
// - Input pull type from control pair
// - Reset gives high-impedance output on all pins
// - Output level follows data register bit
// - Data read returns pin level in input
// - Pins 4 to 7 reserved during conversion
// - Control pair encoding of drive types
// - Direction 0 output, 1 input
//
// The implementer's own choice: strobed register access.
module p4fs_port #(
   parameter int PIN_COUNT = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWordAccess,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   // Peripheral side
   input wire p4fs_pkg::p4fs_periph_out_s periphOut,
   output p4fs_pkg::p4fs_periph_in_s periphIn,
   // Pins
   input wire logic [PIN_COUNT-1:0] padIn,
   output logic [PIN_COUNT-1:0] padOut,
   output logic [PIN_COUNT-1:0] padOe,
   output logic [PIN_COUNT-1:0] padPullUp,
   output logic [PIN_COUNT-1:0] padPullDown
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [PIN_COUNT-1:0] funcSelectLow;
   logic [PIN_COUNT-1:0] funcSelectHigh;
   logic [PIN_COUNT-1:0] pinDirectionReg;
   logic [PIN_COUNT-1:0] driveTypeLowReg;
   logic [PIN_COUNT-1:0] driveTypeHighReg;
   logic [PIN_COUNT-1:0] pinDataReg;
   logic [PIN_COUNT-1:0] padMeta;
   logic [PIN_COUNT-1:0] padSync;

   // ----------------------------------------------------------------
   // Address decode: low lane at regAddr, high lane at regAddr + 1
   // ----------------------------------------------------------------
   wire [15:0] hiAddr = regAddr + 16'h0001;
   wire wrLo = regWrite;
   wire wrHi = regWrite & regWordAccess;
   wire [7:0] wrLoByte = regWrData[7:0];
   wire [7:0] wrHiByte = regWrData[15:8];

   // Byte write enables per register from either lane; pin data from the low lane only
   wire loData = wrLo & (regAddr == p4fs_pkg::OFS_PIN_DATA);
   wire loDir = wrLo & (regAddr == p4fs_pkg::OFS_PIN_DIR);
   wire loDrvL = wrLo & (regAddr == p4fs_pkg::OFS_DRIVE_LOW);
   wire loDrvH = wrLo & (regAddr == p4fs_pkg::OFS_DRIVE_HIGH);
   wire loFunL = wrLo & (regAddr == p4fs_pkg::OFS_FUNC_LOW);
   wire loFunH = wrLo & (regAddr == p4fs_pkg::OFS_FUNC_HIGH);
   wire hiDir = wrHi & (hiAddr == p4fs_pkg::OFS_PIN_DIR);
   wire hiDrvL = wrHi & (hiAddr == p4fs_pkg::OFS_DRIVE_LOW);
   wire hiDrvH = wrHi & (hiAddr == p4fs_pkg::OFS_DRIVE_HIGH);
   wire hiFunL = wrHi & (hiAddr == p4fs_pkg::OFS_FUNC_LOW);
   wire hiFunH = wrHi & (hiAddr == p4fs_pkg::OFS_FUNC_HIGH);

   // Next register values; high lane is only used by word writes
   wire [7:0] next_funcSelectLow = loFunL ? wrLoByte : (hiFunL ? wrHiByte : funcSelectLow);
   wire [7:0] next_funcSelectHigh = loFunH ? wrLoByte : (hiFunH ? wrHiByte : funcSelectHigh);
   wire [7:0] next_pinDirectionReg = loDir ? wrLoByte : (hiDir ? wrHiByte : pinDirectionReg);
   wire [7:0] next_driveTypeLowReg = loDrvL ? wrLoByte : (hiDrvL ? wrHiByte : driveTypeLowReg);
   wire [7:0] next_driveTypeHighReg = loDrvH ? wrLoByte : (hiDrvH ? wrHiByte : driveTypeHighReg);
   wire [7:0] next_pinDataReg = loData ? wrLoByte : pinDataReg;

   // Register file; reset puts every pin in high-impedance output mode
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         funcSelectLow <= p4fs_pkg::RST_FUNC;
         funcSelectHigh <= p4fs_pkg::RST_FUNC;
         pinDirectionReg <= p4fs_pkg::RST_DIR;
         driveTypeLowReg <= p4fs_pkg::RST_DRIVE;
         driveTypeHighReg <= p4fs_pkg::RST_DRIVE;
         pinDataReg <= p4fs_pkg::RST_DATA;
      end
      else
      begin
         funcSelectLow <= next_funcSelectLow;
         funcSelectHigh <= next_funcSelectHigh;
         pinDirectionReg <= next_pinDirectionReg;
         driveTypeLowReg <= next_driveTypeLowReg;
         driveTypeHighReg <= next_driveTypeHighReg;
         pinDataReg <= next_pinDataReg;
      end
   end

   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------
   // Two stages; only padSync is read by any logic
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         padMeta <= '0;
         padSync <= '0;
      end
      else
      begin
         padMeta <= padIn;
         padSync <= padMeta;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Input pins show their level, output pins the stored value
   wire [7:0] dataView = (pinDirectionReg & padSync) | (~pinDirectionReg & pinDataReg);

   function automatic logic [7:0] readByte(input logic [15:0] addr, input logic [7:0] view,
                                           input logic [7:0] dir, input logic [7:0] dl,
                                           input logic [7:0] dh, input logic [7:0] fl,
                                           input logic [7:0] fh);
      logic [7:0] val;
      val = 8'h00;
      if (addr == p4fs_pkg::OFS_PIN_DATA)
         val = view;
      else if (addr == p4fs_pkg::OFS_PIN_DIR)
         val = dir;
      else if (addr == p4fs_pkg::OFS_DRIVE_LOW)
         val = dl;
      else if (addr == p4fs_pkg::OFS_DRIVE_HIGH)
         val = dh;
      else if (addr == p4fs_pkg::OFS_FUNC_LOW)
         val = fl;
      else if (addr == p4fs_pkg::OFS_FUNC_HIGH)
         val = fh;
      return val;
   endfunction

   wire [7:0] rdLo = readByte(regAddr, dataView, pinDirectionReg, driveTypeLowReg,
                              driveTypeHighReg, funcSelectLow, funcSelectHigh);
   wire [7:0] rdHi = regWordAccess ? readByte(hiAddr, dataView, pinDirectionReg, driveTypeLowReg,
                                              driveTypeHighReg, funcSelectLow, funcSelectHigh) : 8'h00;

   // Read data stands only in the cycle after the strobe; zero otherwise
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         regRdData <= 16'h0000;
      else
         regRdData <= regRead ? {rdHi, rdLo} : 16'h0000;
   end

   // ----------------------------------------------------------------
   // Function selection
   // ----------------------------------------------------------------
   logic [1:0] sel [PIN_COUNT];
   logic [1:0] drv [PIN_COUNT];
   logic [PIN_COUNT-1:0] altUsed;
   logic [PIN_COUNT-1:0] altVal;
   logic [PIN_COUNT-1:0] banned;
   logic [PIN_COUNT-1:0] blocked;

   // Per-pin selector and control pairs
   for (genvar i = 0; i < PIN_COUNT; i++)
   begin : g_pair
      assign sel[i] = {funcSelectHigh[i], funcSelectLow[i]};
      assign drv[i] = {driveTypeHighReg[i], driveTypeLowReg[i]};
      // Non-converter use of the top four pins is frozen during conversion
      assign blocked[i] = (i >= p4fs_pkg::CONV_FIRST_PIN) && periphOut.convBusy
                          && (sel[i] != p4fs_pkg::SEL_SECOND);
   end

   // Codes that are banned: 11 everywhere, and 10 on pin 7 as well
   assign banned[7] = (sel[7] == p4fs_pkg::SEL_THIRD) || (sel[7] == p4fs_pkg::SEL_BANNED);
   for (genvar i = 0; i < 7; i++)
   begin : g_ban
      assign banned[i] = (sel[i] == p4fs_pkg::SEL_BANNED);
   end

   // Which pins carry a peripheral output in place of the data bit
   assign altUsed[7] = (sel[7] == p4fs_pkg::SEL_SECOND);
   assign altUsed[6] = (sel[6] == p4fs_pkg::SEL_SECOND) || (sel[6] == p4fs_pkg::SEL_THIRD);
   assign altUsed[5] = (sel[5] == p4fs_pkg::SEL_SECOND) || (sel[5] == p4fs_pkg::SEL_THIRD);
   assign altUsed[4] = 1'b0; // Input-only functions keep the data bit
   assign altUsed[3] = (sel[3] == p4fs_pkg::SEL_SECOND) || (sel[3] == p4fs_pkg::SEL_THIRD);
   assign altUsed[2] = (sel[2] == p4fs_pkg::SEL_THIRD);
   assign altUsed[1] = (sel[1] == p4fs_pkg::SEL_SECOND) || (sel[1] == p4fs_pkg::SEL_THIRD);
   assign altUsed[0] = (sel[0] == p4fs_pkg::SEL_SECOND);

   // Peripheral output values routed to each pin
   assign altVal[7] = periphOut.sensorResistorOut;
   assign altVal[6] = (sel[6] == p4fs_pkg::SEL_SECOND) ? periphOut.refResistorOut
                                                        : periphOut.syncSerialDataOut;
   assign altVal[5] = (sel[5] == p4fs_pkg::SEL_SECOND) ? periphOut.refCapacitorOut
                                                        : periphOut.syncSerialClockOut;
   assign altVal[4] = 1'b0;
   assign altVal[3] = (sel[3] == p4fs_pkg::SEL_SECOND) ? periphOut.asyncTransmitLine
                                                        : periphOut.pulseWidthOutZero;
   assign altVal[2] = periphOut.syncSerialDataOut;
   assign altVal[1] = (sel[1] == p4fs_pkg::SEL_SECOND) ? periphOut.i2cClockOut
                                                        : periphOut.syncSerialClockOut;
   assign altVal[0] = periphOut.i2cDataOut;

   // ----------------------------------------------------------------
   // Peripheral inputs from the synchronised pin levels
   // ----------------------------------------------------------------
   // Unselected inputs idle high so a serial receiver sees no start bit; the oscillation input idles low
   wire sioDataFrom4 = (sel[4] == p4fs_pkg::SEL_THIRD) && !blocked[4];
   wire sioDataFrom0 = (sel[0] == p4fs_pkg::SEL_THIRD);
   wire sioClkFrom5 = (sel[5] == p4fs_pkg::SEL_THIRD) && !blocked[5];
   wire sioClkFrom1 = (sel[1] == p4fs_pkg::SEL_THIRD);

   assign periphIn.asyncReceiveLine = (sel[2] == p4fs_pkg::SEL_SECOND) ? padSync[2] : 1'b1;
   assign periphIn.syncSerialDataIn = sioDataFrom4 ? padSync[4] : (sioDataFrom0 ? padSync[0] : 1'b1);
   assign periphIn.syncSerialClockIn = sioClkFrom5 ? padSync[5] : (sioClkFrom1 ? padSync[1] : 1'b1);
   assign periphIn.i2cClockIn = (sel[1] == p4fs_pkg::SEL_SECOND) ? padSync[1] : 1'b1;
   assign periphIn.i2cDataIn = (sel[0] == p4fs_pkg::SEL_SECOND) ? padSync[0] : 1'b1;
   assign periphIn.oscWaveformInput = (sel[4] == p4fs_pkg::SEL_SECOND) ? padSync[4] : 1'b0;

   // ----------------------------------------------------------------
   // Electrical control per pin
   // ----------------------------------------------------------------
   logic [PIN_COUNT-1:0] next_padOut;
   logic [PIN_COUNT-1:0] next_padOe;
   logic [PIN_COUNT-1:0] next_padPullUp;
   logic [PIN_COUNT-1:0] next_padPullDown;

   for (genvar i = 0; i < PIN_COUNT; i++)
   begin : g_pin
      // Drive type still governs a peripheral's output
      wire isOutput = !pinDirectionReg[i];
      wire hold = banned[i] | blocked[i];
      wire val = altUsed[i] ? altVal[i] : pinDataReg[i];
      wire isPch = (drv[i] == p4fs_pkg::DRV_PCH_OD);
      wire isNch = (drv[i] == p4fs_pkg::DRV_NCH_OD);
      wire isCmos = (drv[i] == p4fs_pkg::DRV_CMOS);
      // A held pin sinks low on the N-channel and CMOS types and floats otherwise
      wire holdOe = isNch | isCmos;
      wire runOe = isCmos | (isPch & val) | (isNch & !val);
      assign next_padOe[i] = isOutput & (hold ? holdOe : runOe);
      assign next_padOut[i] = !hold & (isCmos ? val : isPch);
      // Pulls act only in input mode; code 11 is a plain input
      assign next_padPullDown[i] = !isOutput & isPch;
      assign next_padPullUp[i] = !isOutput & isNch;
   end

   // Pin drive from flip-flops keeps glitches of the muxes off the pads
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         padOut <= '0;
         padOe <= '0;
         padPullUp <= '0;
         padPullDown <= '0;
      end
      else
      begin
         padOut <= next_padOut;
         padOe <= next_padOe;
         padPullUp <= next_padPullUp;
         padPullDown <= next_padPullDown;
      end
   end

   // Software is expected to leave converter pins as plain inputs

endmodule

// file: p4fs_port_monitor.sv
// Checker for the port 4 function-select block, bound to p4fs_port.
// Assumes pads follow a register write two edges later, and no gap in reset.
module p4fs_port_monitor #(
   parameter int PIN_COUNT = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWordAccess,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regRdData,
   // Peripheral side
   input wire p4fs_pkg::p4fs_periph_out_s periphOut,
   input wire p4fs_pkg::p4fs_periph_in_s periphIn,
   // Pins
   input wire logic [PIN_COUNT-1:0] padIn,
   input wire logic [PIN_COUNT-1:0] padOut,
   input wire logic [PIN_COUNT-1:0] padOe,
   input wire logic [PIN_COUNT-1:0] padPullUp,
   input wire logic [PIN_COUNT-1:0] padPullDown
);
   // ------------------------------------------------------------
   // Shadow registers, rebuilt from bus writes
   // ------------------------------------------------------------
   logic [7:0] sh [6];
   // Word writes fill the next byte too, so one loop serves both sizes
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (sys_rst)
            sh[i] <= 8'h00;
         else if (regWrite && regAddr == p4fs_pkg::OFS_PIN_DATA + 16'(i))
            sh[i] <= regWrData[7:0];
         else if (regWrite && regWordAccess && regAddr + 16'h0001 == p4fs_pkg::OFS_PIN_DATA + 16'(i))
            sh[i] <= regWrData[15:8];
      end
   end
   // Expected pin behaviour decoded from the shadow
   wire logic [7:0] outMode = ~sh[1];
   wire logic [7:0] blocked = {8{periphOut.convBusy}} & 8'hF0 & ~(sh[4] & ~sh[5]);
   wire logic [7:0] fixMask = outMode & ((sh[4] & sh[5]) | blocked);
   wire logic [7:0] gpioMask = outMode & ~sh[4] & ~sh[5] & ~blocked;
   wire logic [7:0] expOe = (sh[3] & sh[2]) | (~sh[3] & sh[2] & sh[0]) | (sh[3] & ~sh[2] & ~sh[0]);
   wire logic [7:0] expOut = (sh[3] & sh[2] & sh[0]) | (~sh[3] & sh[2]);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_reset_quiet: assert property ($past(sys_rst) |-> padOe == 0 && (padPullUp | padPullDown) == 0)
      else $error("pins not quiet after reset");
   a_read_idle_zero: assert property (!$past(regRead) |-> regRdData == 16'h0000)
      else $error("read data outside its cycle");
   a_read_func: assert property ($past(regRead && regWordAccess && regAddr == p4fs_pkg::OFS_FUNC_LOW)
      |-> regRdData == $past({sh[5], sh[4]})) else $error("selector word read wrong");
   a_input_no_drive: assert property ((padOe & $past(sh[1])) == 8'h00)
      else $error("input pin driven");
   a_pull_select: assert property (padPullUp == $past(sh[1] & sh[3] & ~sh[2])
      && padPullDown == $past(sh[1] & ~sh[3] & sh[2])) else $error("pull enables wrong");
   a_gpio_drive: assert property ((padOe & $past(gpioMask)) == $past(expOe & gpioMask))
      else $error("drive enable wrong");
   a_gpio_level: assert property ((padOut & padOe & $past(gpioMask)) == ($past(expOut & gpioMask) & padOe))
      else $error("driven level wrong");
   a_banned_fixed: assert property (((padOe ^ $past(sh[3])) & $past(fixMask)) == 8'h00
      && (padOut & padOe & $past(fixMask)) == 8'h00) else $error("fixed pin state wrong");
   a_uart_tx_route: assert property ($past(outMode[3] && sh[3][3] && sh[2][3] && sh[4][3] && !sh[5][3])
      |-> padOe[3] && padOut[3] == $past(periphOut.asyncTransmitLine)) else $error("transmit not routed");
   a_uart_rx_route: assert property (sh[4][2] && !sh[5][2] |-> periphIn.asyncReceiveLine == $past(padIn[2], 2))
      else $error("receive not routed");

   // Main scenarios reached
   cover property (periphOut.convBusy && |fixMask);
   cover property (|padPullUp);
   cover property ($past(regRead) && regRdData != 16'h0000);
endmodule

bind p4fs_port p4fs_port_monitor #(.PIN_COUNT(PIN_COUNT)) mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .regAddr(regAddr), .regWrData(regWrData), .regWordAccess(regWordAccess), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .periphOut(periphOut), .periphIn(periphIn), .padIn(padIn),
   .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp), .padPullDown(padPullDown));

// file: p4fs_pin_model.sv
// Board model of the eight port 4 pins: resolves each wire's level.
// The device's drive wins where the bench also enables its own driver on a pin.
module p4fs_pin_model (
   // Clock
   input wire logic clk_sys,
   // Device pin controls
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] padPullUp,
   input wire logic [7:0] padPullDown,
   // Outside drivers
   input wire logic [7:0] extVal,
   input wire logic [7:0] extEn,
   // Resolved level
   output logic [7:0] padIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lastLvl = 8'h00;
   // A floating pin toggles each cycle so no stale level passes for a real one
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extVal[i] : padPullUp[i] ? 1'b1 : padPullDown[i] ? 1'b0
            : ~lastLvl[i];
   end
   // Last level seen on each wire
   always @(posedge clk_sys)
      lastLvl <= padIn;
endmodule

// file: tb_port4_function_select_io.sv
// Testbench for the port 4 function-select block.
// Assumes the bound checker and the board model sit beside the design.
`define CHK(nm, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("MISMATCH %s expected %h seen %h", nm, e, g); \
      end \
   end
module tb_port4_function_select_io;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] regAddr = 16'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic regWordAccess = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdData;
   p4fs_pkg::p4fs_periph_out_s periphOut = '0;
   p4fs_pkg::p4fs_periph_in_s periphIn;
   logic [7:0] padIn, padOut, padOe, padPullUp, padPullDown;
   logic [7:0] extVal = 8'h00;
   logic [7:0] extEn = 8'h00;
   logic [7:0] oeTab [4] = '{8'h00, 8'hF0, 8'h0F, 8'hFF};
   int mismatches = 0;
   int comparisons = 0;

   p4fs_port #(.PIN_COUNT(8)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWordAccess(regWordAccess), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .periphOut(periphOut), .periphIn(periphIn), .padIn(padIn), .padOut(padOut),
      .padOe(padOe), .padPullUp(padPullUp), .padPullDown(padPullDown));
   p4fs_pin_model board (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
      .padPullDown(padPullDown), .extVal(extVal), .extEn(extEn), .padIn(padIn));

   // 40 MHz clock
   initial
   begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWordAccess <= w;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e, input string nm);
      @(posedge clk_sys);
      regAddr <= a;
      regWordAccess <= w;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      `CHK(nm, e, regRdData)
   endtask
   // Pads are registered one edge behind the registers
   task automatic settle;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog, over thirty times the expected run of about 150 cycles
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      mismatches++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++) rd(p4fs_pkg::OFS_PIN_DATA + 16'(i), 1'b0, 16'h0000, "reset value");
      `CHK("oe after reset", 8'h00, padOe)
      $display("test reset done");
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'h5AA5, 1'b1);
      rd(p4fs_pkg::OFS_FUNC_LOW, 1'b1, 16'h5AA5, "selector word");
      rd(p4fs_pkg::OFS_FUNC_HIGH, 1'b0, 16'h005A, "selector high");
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'h0000, 1'b1);
      $display("test selectors done");
      wr(p4fs_pkg::OFS_PIN_DATA, 16'h00F0, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         wr(p4fs_pkg::OFS_DRIVE_LOW, {{8{k[1]}}, {8{k[0]}}}, 1'b1);
         settle();
         `CHK("drive enable", oeTab[k], padOe)
         `CHK("drive level", (k[0] ? 8'hF0 : 8'h00) & oeTab[k], padOut & padOe)
      end
      $display("test output types done");
      wr(p4fs_pkg::OFS_PIN_DIR, 16'h00FF, 1'b0);
      extEn <= 8'hFF;
      extVal <= 8'h3C;
      for (int k = 0; k < 4; k++)
      begin
         wr(p4fs_pkg::OFS_DRIVE_LOW, {{8{k[1]}}, {8{k[0]}}}, 1'b1);
         settle();
         `CHK("input enable", 8'h00, padOe)
         `CHK("pull up", (k == 2) ? 8'hFF : 8'h00, padPullUp)
         `CHK("pull down", (k == 1) ? 8'hFF : 8'h00, padPullDown)
      end
      rd(p4fs_pkg::OFS_PIN_DATA, 1'b0, 16'h003C, "input level");
      $display("test input modes done");
      wr(p4fs_pkg::OFS_PIN_DIR, 16'h0004, 1'b0);
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'h000C, 1'b1);
      for (int v = 0; v < 2; v++)
      begin
         periphOut.asyncTransmitLine <= v[0];
         extVal <= {5'h00, ~v[0], 2'h0};
         settle();
         `CHK("transmit pin", v[0], padOut[3])
         `CHK("receive line", ~v[0], periphIn.asyncReceiveLine)
      end
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'h0800, 1'b1);
      periphOut.pulseWidthOutZero <= 1'b1;
      periphOut.asyncTransmitLine <= 1'b0;
      settle();
      `CHK("pulse pin", 1'b1, padOut[3])
      $display("test peripherals done");
      wr(p4fs_pkg::OFS_PIN_DIR, 16'h0000, 1'b0);
      extEn <= 8'h00;
      wr(p4fs_pkg::OFS_PIN_DATA, 16'h00FF, 1'b0);
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'hFFFF, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         wr(p4fs_pkg::OFS_DRIVE_LOW, {{8{k[1]}}, {8{k[0]}}}, 1'b1);
         settle();
         `CHK("banned enable", k[1] ? 8'hFF : 8'h00, padOe)
         `CHK("banned level", 8'h00, padOut & padOe)
      end
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'h0000, 1'b1);
      periphOut.convBusy <= 1'b1;
      settle();
      `CHK("busy enable", 8'hFF, padOe)
      `CHK("busy level", 8'h0F, padOut)
      $display("test conversion hold done");
      // Pins 4 and 0 as plain inputs; drive code 11 leaves them high-impedance
      wr(p4fs_pkg::OFS_PIN_DIR, 16'h0011, 1'b0);
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'h1001, 1'b1);
      extEn <= 8'hFF;
      extVal <= 8'h00;
      settle();
      `CHK("data line in", 1'b0, periphIn.i2cDataIn)
      `CHK("busy serial in", 1'b1, periphIn.syncSerialDataIn)
      periphOut.convBusy <= 1'b0;
      settle();
      `CHK("serial data in", 1'b0, periphIn.syncSerialDataIn)
      wr(p4fs_pkg::OFS_FUNC_LOW, 16'h0010, 1'b1);
      extVal <= 8'h10;
      settle();
      `CHK("waveform in", 1'b1, periphIn.oscWaveformInput)
      $display("test peripheral inputs done");
      complete_run();
   end
endmodule
